// *** rtl/pfo_fault_override.sv ***
// pfo_fault_override: fault override for a pwm output stage
// assumes period_start is a one-cycle pulse on aclk from the pwm time base,
// fault_input_n and breakpoint_hit arrive asynchronously from pins.
//
// Notes on behaviour
// - fault_mode_select clear picks latched mode, set picks cycle mode.
// - fault_input_n is active low; low asserts a fault, high removes it.
// - latched mode keeps outputs off until input high and status cleared.
// - latched mode re-enables outputs only at the next period start.
// - cycle mode holds outputs inactive while the fault input is low.
// - cycle mode clears status and resumes at the next period start.
// - while in fault, every pwm output is forced to its inactive level.
// - fault_status reads set from fault assertion until it is cleared.
// - with breakpoint_fault_enable set, a breakpoint hit acts as a fault.
// - with breakpoint_fault_enable clear, breakpoint hits do nothing.
`timescale 1ns/10ps

module pfo_fault_override #(
  parameter int PWM_W = 6
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // axi4-lite write address
  input  wire logic [3:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // axi4-lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // axi4-lite read address
  input  wire logic [3:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // axi4-lite read data
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // pwm path
  input  wire logic [PWM_W-1:0] pwm_in,
  input  wire logic [PWM_W-1:0] pwm_inactive,
  input  wire logic             period_start,
  output logic [PWM_W-1:0]      pwm_out,
  // fault sources
  input  wire logic             fault_input_n,
  input  wire logic             breakpoint_hit,
  // status
  output logic                  fault_active,
  output logic                  irq
);

  // pin synchronisers
  logic [1:0] flt_sync_q;
  logic [1:0] brk_sync_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flt_sync_q <= 2'b11;
      brk_sync_q <= 2'b00;
    end
    else
    begin
      flt_sync_q <= {flt_sync_q[0], fault_input_n};
      brk_sync_q <= {brk_sync_q[0], breakpoint_hit};
    end
  end

  // configuration and state registers
  pfo_pkg::pfo_cfg_s   cfg_q;
  logic                status_q;
  logic                status_d;
  pfo_pkg::pfo_state_e state_q;
  pfo_pkg::pfo_state_e state_d;
  logic [1:0]          irq_stat_q;
  logic [1:0]          irq_mask_q;

  // fault request
  wire pin_fault   = !flt_sync_q[1] && cfg_q.fault_input_enable;
  wire brk_fault   = brk_sync_q[1]
                     && cfg_q.breakpoint_fault_enable;
  wire fault_req   = pin_fault || brk_fault;
  wire cycle_mode  = cfg_q.fault_mode_select == pfo_pkg::MODE_CYCLE;

  // bus write decode
  logic aw_held_q;
  logic w_held_q;
  logic [3:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  wire aw_fire   = s_axi_awvalid && s_axi_awready;
  wire w_fire    = s_axi_wvalid && s_axi_wready;
  wire wr_go     = aw_held_q && w_held_q && !s_axi_bvalid;
  wire wr_cfg    = wr_go && aw_addr_q == pfo_pkg::FAULT_CONFIG_OFS
                   && w_strb_q[0];
  wire wr_mask   = wr_go && aw_addr_q == pfo_pkg::IRQ_MASK_OFS
                   && w_strb_q[0];
  wire wr_ok     = aw_addr_q == pfo_pkg::FAULT_CONFIG_OFS
                   || aw_addr_q == pfo_pkg::IRQ_MASK_OFS;
  wire sw_clr    = wr_cfg && !w_data_q[pfo_pkg::FAULT_STATUS_BIT];

  // read decode
  wire ar_fire   = s_axi_arvalid && s_axi_arready;
  wire rd_stat   = ar_fire && s_axi_araddr == pfo_pkg::IRQ_STATUS_OFS;
  wire rd_ok     = s_axi_araddr == pfo_pkg::FAULT_CONFIG_OFS
                   || s_axi_araddr == pfo_pkg::IRQ_STATUS_OFS
                   || s_axi_araddr == pfo_pkg::IRQ_MASK_OFS
                   || s_axi_araddr == pfo_pkg::FAULT_STATE_OFS;
  wire [7:0] cfg_rd = {cfg_q.breakpoint_fault_enable, 4'h0, status_q,
                       cfg_q.fault_mode_select, cfg_q.fault_input_enable};
  wire [31:0] rd_mux =
    s_axi_araddr == pfo_pkg::FAULT_CONFIG_OFS ? {24'h00_0000, cfg_rd} :
    s_axi_araddr == pfo_pkg::IRQ_STATUS_OFS   ? {30'h0, irq_stat_q}   :
    s_axi_araddr == pfo_pkg::IRQ_MASK_OFS     ? {30'h0, irq_mask_q}   :
    s_axi_araddr == pfo_pkg::FAULT_STATE_OFS  ? {29'h0, state_q}      :
    pfo_pkg::READ_ZERO;

  // fault state machine
  always_comb
  begin
    state_d  = state_q;
    status_d = status_q;
    if (fault_req)
      status_d = 1'b1;
    else if (sw_clr && !cycle_mode)
      status_d = 1'b0;
    case (state_q)
      pfo_pkg::PFO_RUN:
      begin
        if (fault_req)
          state_d = pfo_pkg::PFO_FAULT;
      end
      pfo_pkg::PFO_FAULT:
      begin
        if (!fault_req && cycle_mode)
          state_d = pfo_pkg::PFO_WAIT_PER;
        else if (!fault_req && !status_d)
          state_d = pfo_pkg::PFO_WAIT_PER;
      end
      pfo_pkg::PFO_WAIT_PER:
      begin
        if (fault_req)
          state_d = pfo_pkg::PFO_FAULT;
        else if (!cycle_mode && status_q)
          state_d = pfo_pkg::PFO_FAULT;
        else if (period_start)
        begin
          state_d = pfo_pkg::PFO_RUN;
          if (cycle_mode)
            status_d = 1'b0;
        end
      end
      default:
        state_d = pfo_pkg::PFO_FAULT;
    endcase
  end

  wire in_fault_d = state_d != pfo_pkg::PFO_RUN;
  wire ev_fault   = state_q == pfo_pkg::PFO_RUN && in_fault_d;
  wire ev_recov   = state_q != pfo_pkg::PFO_RUN && !in_fault_d;
  wire [1:0] ev   = {ev_recov, ev_fault};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q  <= pfo_pkg::PFO_RUN;
      status_q <= 1'b0;
      pwm_out  <= '0;
      fault_active <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      status_q <= status_d;
      fault_active <= in_fault_d;
      pwm_out  <= in_fault_d ? pwm_inactive : pwm_in;
    end
  end

  // configuration, mask and sticky interrupt status; set wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_q      <= '0;
      irq_mask_q <= pfo_pkg::IRQ_MASK_RST;
      irq_stat_q <= 2'h0;
      irq        <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= '{w_data_q[pfo_pkg::BREAKPOINT_FAULT_ENABLE_BIT],
                   w_data_q[pfo_pkg::FAULT_MODE_SELECT_BIT],
                   w_data_q[pfo_pkg::FAULT_INPUT_ENABLE_BIT]};
      if (wr_mask)
        irq_mask_q <= w_data_q[1:0];
      irq_stat_q <= (rd_stat ? 2'h0 : irq_stat_q) | ev;
      irq <= |(((rd_stat ? 2'h0 : irq_stat_q) | ev) & irq_mask_q);
    end
  end

  // axi4-lite handshakes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= 4'h0;
      w_data_q      <= pfo_pkg::READ_ZERO;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pfo_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= pfo_pkg::READ_ZERO;
      s_axi_rresp   <= pfo_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_held_q     <= 1'b1;
        aw_addr_q     <= {s_axi_awaddr[3:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (w_fire)
      begin
        w_held_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? pfo_pkg::RESP_OKAY : pfo_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (ar_fire)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_ok ? pfo_pkg::RESP_OKAY : pfo_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // checks
  AST_FAULT_FORCES: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_active |-> pwm_out == $past(pwm_inactive))
    else $error("pwm not forced inactive in fault");
  AST_PIN_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_fault |=> status_q && state_q == pfo_pkg::PFO_FAULT)
    else $error("pin fault not taken");
  AST_IGNORE_PIN: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == pfo_pkg::PFO_RUN && !cfg_q.fault_input_enable && !brk_fault
    |=> state_q == pfo_pkg::PFO_RUN)
    else $error("disabled input caused fault");
  AST_LATCH_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == pfo_pkg::PFO_FAULT && !cycle_mode && status_q && !sw_clr
    |=> state_q == pfo_pkg::PFO_FAULT)
    else $error("latched fault left without clear");
  AST_RESUME_ON_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(fault_active) |-> $past(period_start))
    else $error("resume not on period start");
  AST_CYCLE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    cycle_mode && pin_fault |=> fault_active)
    else $error("cycle mode released while input low");
  AST_CYCLE_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    cycle_mode && state_q == pfo_pkg::PFO_WAIT_PER && period_start
    && !fault_req |=> !status_q && !fault_active)
    else $error("cycle mode recovery wrong");
  AST_BRK_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
    brk_fault |=> ##1 fault_active)
    else $error("breakpoint fault not applied");
  AST_BRK_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == pfo_pkg::PFO_RUN && !pin_fault
    && !cfg_q.breakpoint_fault_enable |=> state_q == pfo_pkg::PFO_RUN)
    else $error("breakpoint acted while disabled");
  AST_STATUS_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    status_q && !cycle_mode && !sw_clr |=> status_q)
    else $error("status dropped without clear");

endmodule

// *** rtl/pfo_pkg.sv ***
// pfo_pkg: shared constants and types for the pwm fault override block
// assumes a 32-bit axi4-lite register bus and an 8-bit config register
package pfo_pkg;

  // register byte offsets
  localparam logic [3:0] FAULT_CONFIG_OFS = 4'h0;
  localparam logic [3:0] IRQ_STATUS_OFS   = 4'h4;
  localparam logic [3:0] IRQ_MASK_OFS     = 4'h8;
  localparam logic [3:0] FAULT_STATE_OFS  = 4'hC;

  // fault_config field positions
  localparam int FAULT_INPUT_ENABLE_BIT      = 0;
  localparam int FAULT_MODE_SELECT_BIT       = 1;
  localparam int FAULT_STATUS_BIT            = 2;
  localparam int BREAKPOINT_FAULT_ENABLE_BIT = 7;

  // reset values
  localparam logic [7:0]  FAULT_CONFIG_RST = 8'h00;
  localparam logic [1:0]  IRQ_MASK_RST     = 2'h0;
  localparam logic [31:0] READ_ZERO        = 32'h0000_0000;

  // interrupt status bits
  localparam int IRQ_FAULT_SET_BIT  = 0;
  localparam int IRQ_RECOVERED_BIT  = 1;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // mode encoding
  localparam logic MODE_LATCHED = 1'b0;
  localparam logic MODE_CYCLE   = 1'b1;

  // fault state machine
  typedef enum logic [2:0] {
    PFO_RUN      = 3'b001,
    PFO_FAULT    = 3'b010,
    PFO_WAIT_PER = 3'b100
  } pfo_state_e;

  // configuration fields
  typedef struct packed {
    logic breakpoint_fault_enable;
    logic fault_mode_select;
    logic fault_input_enable;
  } pfo_cfg_s;

endpackage

// *** bench/pfo_fault_src.sv ***
// pfo_fault_src: behavioural power-stage protection driving the fault pin
// assumes trip requests come from the bench on aclk; lag sets response speed
`timescale 1ns/10ps

module pfo_fault_src (
  // clock and request
  input  wire logic       aclk,
  input  wire logic       trip,
  input  wire logic [1:0] lag,
  // fault pin
  output logic            fault_input_n
);
  int   cnt   = 0;
  logic pin_q = 1'b1;

  assign fault_input_n = pin_q;

  // pin follows the request lag+1 cycles later, low means fault
  always @(posedge aclk)
  begin
    if (trip == pin_q)
    begin
      if (cnt >= int'(lag))
      begin
        pin_q <= ~trip;
        cnt <= 0;
      end
      else
        cnt <= cnt + 1;
    end
  end
endmodule

// *** bench/testbench.sv ***
// testbench: random and corner tests of the pwm fault override block
// assumes the design package is compiled first and registers are 32 bits
`timescale 1ns/10ps

module testbench;
  localparam logic [3:0] CFG = pfo_pkg::FAULT_CONFIG_OFS;
  localparam logic [3:0] IST = pfo_pkg::IRQ_STATUS_OFS;
  localparam logic [3:0] MSK = pfo_pkg::IRQ_MASK_OFS;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, lag = 2'h0;
  logic [5:0]  pwm_in = 6'h00, pwm_inactive = 6'h00, pwm_out;
  logic        period_start = 1'b0, trip = 1'b0, breakpoint_hit = 1'b0;
  logic        fault_input_n, fault_active, irq;
  int          fail_count = 0, tests_run = 0, cyc = 0;

  pfo_fault_override u_pfo_fault_override (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_in,
    .pwm_inactive, .period_start, .pwm_out, .fault_input_n,
    .breakpoint_hit, .fault_active, .irq);
  pfo_fault_src u_pfo_fault_src (.aclk, .trip, .lag, .fault_input_n);

  initial
  begin
    forever #12.5 aclk = ~aclk;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      test_done;
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  function automatic logic [31:0] cfg_word(input logic bfe, input logic st,
                                           input logic md, input logic en);
    cfg_word = 32'h0000_0000;
    cfg_word[pfo_pkg::BREAKPOINT_FAULT_ENABLE_BIT] = bfe;
    cfg_word[pfo_pkg::FAULT_STATUS_BIT]            = st;
    cfg_word[pfo_pkg::FAULT_MODE_SELECT_BIT]       = md;
    cfg_word[pfo_pkg::FAULT_INPUT_ENABLE_BIT]      = en;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (aw && s_axi_awready)
      begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (aw || w);
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic pulse;
    @(posedge aclk);
    period_start <= 1'b1;
    @(posedge aclk);
    period_start <= 1'b0;
  endtask

  task automatic wfa(input logic v);
    int k;
    k = 0;
    do
    begin
      @(posedge aclk);
      k++;
    end while (fault_active !== v && k < 16);
  endtask

  initial
  begin
    rd = $urandom(26);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(CFG);
    chk("config reset", 32'h0000_0000, rd);
    rdr(pfo_pkg::FAULT_STATE_OFS);
    chk("state reset", 32'h0000_0001, rd);
    wr(pfo_pkg::FAULT_STATE_OFS, 32'hFFFF_FFFF);
    chk("read-only bresp", 32'(pfo_pkg::RESP_SLVERR), 32'(rs));
    s_axi_wstrb <= 4'h0;
    wr(CFG, 32'h0000_0083);
    s_axi_wstrb <= 4'hF;
    chk("masked bresp", 32'(pfo_pkg::RESP_OKAY), 32'(rs));
    rdr(CFG);
    chk("strobe off", cfg_word(1'b0, 1'b0, 1'b0, 1'b0), rd);
    chk("rresp", 32'(pfo_pkg::RESP_OKAY), 32'(rs));
    $display("test registers done");
    repeat (3)
    begin
      wr(CFG, 32'h0000_0000);
      wr(MSK, 32'h0000_0003);
      rdr(IST);
      pwm_in <= 6'($urandom);
      pwm_inactive <= 6'($urandom);
      lag <= 2'($urandom);
      trip <= 1'b1;
      wt(10);
      chk("fault_active off", 32'h0, 32'(fault_active));
      chk("pwm_out pass", 32'(pwm_in), 32'(pwm_out));
      wr(CFG, 32'h0000_0001);
      wfa(1'b1);
      chk("fault_active on", 32'h1, 32'(fault_active));
      chk("pwm_out forced", 32'(pwm_inactive), 32'(pwm_out));
      chk("irq raised", 32'h1, 32'(irq));
      rdr(IST);
      chk("irq status", 32'h0000_0001, rd);
      wt(3);
      chk("irq cleared", 32'h0, 32'(irq));
      wr(CFG, 32'h0000_0001);
      rdr(CFG);
      chk("status kept", cfg_word(1'b0, 1'b1, 1'b0, 1'b1), rd);
      trip <= 1'b0;
      wt(10);
      pulse;
      wt(3);
      chk("latched hold", 32'h1, 32'(fault_active));
      wr(CFG, 32'h0000_0001);
      wt(4);
      chk("no mid-period", 32'h1, 32'(fault_active));
      pulse;
      wt(3);
      chk("latched resume", 32'h0, 32'(fault_active));
      chk("pwm_out back", 32'(pwm_in), 32'(pwm_out));
      $display("test latched done");
      rdr(IST);
      wr(CFG, 32'h0000_0003);
      trip <= 1'b1;
      wfa(1'b1);
      pulse;
      wt(3);
      chk("cycle hold", 32'h1, 32'(fault_active));
      trip <= 1'b0;
      wt(10);
      rdr(CFG);
      chk("cycle status", cfg_word(1'b0, 1'b1, 1'b1, 1'b1), rd);
      chk("cycle wait", 32'h1, 32'(fault_active));
      pulse;
      wt(3);
      chk("cycle resume", 32'h0, 32'(fault_active));
      rdr(CFG);
      chk("auto clear", cfg_word(1'b0, 1'b0, 1'b1, 1'b1), rd);
      rdr(IST);
      chk("irq events", 32'h0000_0003, rd);
      $display("test cycle done");
      wr(MSK, 32'h0000_0000);
      breakpoint_hit <= 1'b1;
      wt(8);
      chk("break ignored", 32'h0, 32'(fault_active));
      wr(CFG, 32'h0000_0083);
      wfa(1'b1);
      chk("break fault", 32'(pwm_inactive), 32'(pwm_out));
      chk("irq masked", 32'h0, 32'(irq));
      breakpoint_hit <= 1'b0;
      wt(6);
      pulse;
      wt(3);
      chk("break resume", 32'h0, 32'(fault_active));
      $display("test breakpoint done");
    end
    test_done;
  end
endmodule
